// >>> common/idle_pd_pkg.sv
// Constants, register layout and decode functions for DRAM idle and power-down timing
package idle_pd_pkg;

    // ****************************************
    // Geometry and register map
    // ****************************************
    localparam int NUM_RANKS = 2;
    localparam int NUM_BANKS = 4;
    localparam int ADDR_W = 12;
    localparam int CNT_W = 6;
    localparam logic [ADDR_W-1:0] IDLE_TIMING_ADDR = 12'h118;
    localparam logic [ADDR_W-1:0] CTRL_MODE_ADDR = 12'h120;
    localparam logic [31:0] IDLE_TIMING_RESET = 32'h000003ff;
    localparam logic [31:0] CTRL_MODE_RESET = 32'h40002801;
    // Bits of the timing register that hold storage
    localparam logic [31:0] IDLE_TIMING_RW_MASK = 32'hc00303ff;
    localparam int INIT_DONE_BIT = 29;

    // Field positions
    localparam int CKE_LOW_LSB = 30;
    localparam int EXIT_LSB = 8;
    localparam int PAGE_LSB = 5;
    localparam int PD_LSB = 0;

    // ****************************************
    // Encodings
    // ****************************************
    localparam logic [1:0] CKE_LOW_DDR = 2'h0;
    localparam logic [1:0] CKE_LOW_DDR2 = 2'h2;
    localparam logic [1:0] EXIT_TWO = 2'h2;
    localparam logic [1:0] EXIT_ONE = 2'h3;
    localparam logic [2:0] PAGE_EIGHT = 3'h1;
    localparam logic [2:0] PAGE_NEVER = 3'h7;
    localparam logic [4:0] PD_NEVER = 5'h1f;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    localparam logic [CNT_W-1:0] CNT_TWO = 6'h02;
    localparam logic [CNT_W-1:0] CNT_THREE = 6'h03;
    localparam logic [CNT_W-1:0] CNT_EIGHT = 6'h08;

    typedef enum logic [3:0] {
        ST_ACTIVE = 4'h1,
        ST_LOW = 4'h2,
        ST_DOWN = 4'h4,
        ST_EXIT = 4'h8
    } rank_state_t;

    // CKE minimum low time in clocks; reserved codes take the longer value
    function automatic logic [CNT_W-1:0] cke_low_clocks(input logic [1:0] code);
        cke_low_clocks = (code == CKE_LOW_DDR) ? CNT_ONE : CNT_THREE;
    endfunction : cke_low_clocks

    // Exit delay in clocks; reserved codes take the safer two clocks
    function automatic logic [CNT_W-1:0] exit_clocks(input logic [1:0] code);
        exit_clocks = (code == EXIT_ONE) ? CNT_ONE : CNT_TWO;
    endfunction : exit_clocks

endpackage : idle_pd_pkg

// >>> common/idle_if.sv
// Interface between the channel controller and one idle counter
`timescale 1ns/100ps
`default_nettype none
interface idle_if;
    logic restart;
    logic enable;
    logic [5:0] limit;
    logic expired;
    modport owner (output restart, output enable, output limit, input expired);
    modport timer (input restart, input enable, input limit, output expired);
endinterface : idle_if
`default_nettype wire

// >>> hw/idle_counter.sv
// Saturating idle counter that flags a configured run of unaccessed clocks
`timescale 1ns/100ps
`default_nettype none
module idle_counter
    import idle_pd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Control from owner
    idle_if.timer tmr
);

    logic [CNT_W-1:0] count_q;
    logic expired_q;

    // Count only consecutive idle clocks; saturate so a long idle never wraps
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            count_q <= '0;
        end else if (tmr.restart) begin
            count_q <= '0;
        end else if (count_q != {CNT_W{1'b1}}) begin
            count_q <= count_q + CNT_ONE;
        end
    end

    // Expiry is held off while disabled; the restart cycle itself is never idle
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            expired_q <= 1'b0;
        end else begin
            // One bit wider, so a saturated count still reads as expired instead of wrapping
            expired_q <= tmr.enable && !tmr.restart
                       && (({1'b0, count_q} + {1'b0, CNT_ONE}) >= {1'b0, tmr.limit});
        end
    end

    assign tmr.expired = expired_q;

endmodule : idle_counter
`default_nettype wire

// >>> hw/dram_idle_power_down_timing.sv
// Idle timing, page-close scheduling and rank power-down for one DRAM channel
`timescale 1ns/100ps
`default_nettype none
module dram_idle_power_down_timing
    import idle_pd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Scheduler activity
    input wire logic [NUM_BANKS-1:0] bank_access,
    input wire logic [NUM_BANKS-1:0] bank_open,
    input wire logic [NUM_RANKS-1:0] rank_access,
    // Results
    output logic [NUM_BANKS-1:0] page_close_req,
    output logic [NUM_RANKS-1:0] cke,
    output logic [NUM_RANKS-1:0] cmd_ok
);

    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] timing_q;
    logic init_done_q;
    logic [31:0] wmask;
    logic [1:0] cke_low_code;
    logic [1:0] exit_code;
    logic [2:0] page_code;
    logic [4:0] pd_code;
    logic timing_wr;
    logic mode_wr;

    // Address decode shared by the storage and flag writes
    assign timing_wr = reg_wr && reg_addr == IDLE_TIMING_ADDR;
    assign mode_wr = reg_wr && reg_addr == CTRL_MODE_ADDR;

    // Byte enables widen into a bit mask
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{reg_be[i]}};
        end
    end

    // Only documented storage bits take writes; read-only bits keep their value
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            timing_q <= IDLE_TIMING_RESET;
        end else if (timing_wr) begin
            timing_q <= (timing_q & ~(wmask & IDLE_TIMING_RW_MASK))
                      | (reg_wdata & wmask & IDLE_TIMING_RW_MASK);
        end
    end

    // Init flag records firmware state only and steers nothing here
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            init_done_q <= 1'b0;
        end else if (mode_wr && reg_be[INIT_DONE_BIT/8]) begin
            init_done_q <= reg_wdata[INIT_DONE_BIT];
        end
    end

    // Read data one clock after the strobe; unmapped addresses read zero
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd && reg_addr == IDLE_TIMING_ADDR) begin
                reg_rdata <= timing_q;
            end else if (reg_rd && reg_addr == CTRL_MODE_ADDR) begin
                reg_rdata <= (CTRL_MODE_RESET & ~(32'h1 << INIT_DONE_BIT))
                           | ({31'h0, init_done_q} << INIT_DONE_BIT);
            end else if (reg_rd) begin
                reg_rdata <= '0;
            end
        end
    end

    assign cke_low_code = timing_q[CKE_LOW_LSB +: 2];
    assign exit_code = timing_q[EXIT_LSB +: 2];
    assign page_code = timing_q[PAGE_LSB +: 3];
    assign pd_code = timing_q[PD_LSB +: 5];

    // ****************************************
    // Page-close idle timers, one per bank
    // ****************************************
    idle_if bank_tmr [NUM_BANKS] ();

    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        // Only code 001 closes pages; 111 and reserved codes leave them open
        assign bank_tmr[b].enable = (page_code == PAGE_EIGHT) && bank_open[b];
        assign bank_tmr[b].limit = CNT_EIGHT;
        assign bank_tmr[b].restart = bank_access[b];

        idle_counter u_bank_idle (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .tmr(bank_tmr[b])
        );

        // Request stays up until the bank is used or closed
        always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
                page_close_req[b] <= 1'b0;
            end else begin
                page_close_req[b] <= bank_tmr[b].expired && bank_open[b]
                                   && !bank_access[b];
            end
        end
    end

    // ****************************************
    // Rank power-down, one state machine per rank
    // ****************************************
    idle_if rank_tmr [NUM_RANKS] ();

    for (genvar r = 0; r < NUM_RANKS; r++) begin : g_rank
        rank_state_t state_q;
        logic [CNT_W-1:0] wait_q;
        logic wake_q;
        logic go_down;
        logic wake_now;

        // All ones disables the timer; the field value is the idle clock count
        assign rank_tmr[r].enable = (pd_code != PD_NEVER) && (state_q == ST_ACTIVE);
        assign rank_tmr[r].limit = {1'b0, pd_code};
        assign rank_tmr[r].restart = rank_access[r] || state_q != ST_ACTIVE;

        // Idle run just ran out with nothing queued for this rank
        assign go_down = rank_tmr[r].expired && !rank_access[r];
        // Minimum low time is over and a command is waiting
        assign wake_now = wait_q == '0 && (wake_q || rank_access[r]);

        idle_counter u_rank_idle (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .tmr(rank_tmr[r])
        );

        // A wake request during the minimum low time is remembered, not dropped
        always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
                wake_q <= 1'b0;
            end else if (state_q == ST_LOW) begin
                wake_q <= wake_q || rank_access[r];
            end else begin
                wake_q <= 1'b0;
            end
        end

        // CKE low for the minimum time, then high with the exit delay before commands
        always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
                state_q <= ST_ACTIVE;
                wait_q <= '0;
            end else begin
                case (state_q)
                    ST_ACTIVE: begin
                        if (go_down) begin
                            state_q <= ST_LOW;
                            wait_q <= cke_low_clocks(cke_low_code) - CNT_ONE;
                        end
                    end
                    ST_LOW: begin
                        if (wait_q != '0) begin
                            wait_q <= wait_q - CNT_ONE;
                        end else if (wake_q || rank_access[r]) begin
                            state_q <= ST_EXIT;
                            wait_q <= exit_clocks(exit_code) - CNT_ONE;
                        end else begin
                            state_q <= ST_DOWN;
                        end
                    end
                    ST_DOWN: begin
                        if (rank_access[r]) begin
                            state_q <= ST_EXIT;
                            wait_q <= exit_clocks(exit_code) - CNT_ONE;
                        end
                    end
                    ST_EXIT: begin
                        // Counts from the first clock CKE is high to the command clock
                        if (wait_q != '0) begin
                            wait_q <= wait_q - CNT_ONE;
                        end else begin
                            state_q <= ST_ACTIVE;
                        end
                    end
                    default: begin
                        state_q <= ST_ACTIVE;
                        wait_q <= '0;
                    end
                endcase
            end
        end

        // Pin-facing outputs registered from the next-state view
        always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
                cke[r] <= 1'b1;
                cmd_ok[r] <= 1'b1;
            end else begin
                cke[r] <= (state_q == ST_ACTIVE && !go_down)
                        || state_q == ST_EXIT
                        || (state_q == ST_LOW && wake_now)
                        || (state_q == ST_DOWN && rank_access[r]);
                cmd_ok[r] <= (state_q == ST_ACTIVE && !go_down)
                           || (state_q == ST_EXIT && wait_q == '0);
            end
        end
    end

endmodule : dram_idle_power_down_timing
`default_nettype wire

// >>> dv/idle_pd_checker.sv
// Port assertions for the idle timing and power-down block
`timescale 1ns/100ps
`default_nettype none
module idle_pd_checker
    import idle_pd_pkg::*;
(
    // Clock, reset, register writes
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    // Activity and results
    input wire logic [NUM_BANKS-1:0] bank_access,
    input wire logic [NUM_BANKS-1:0] bank_open,
    input wire logic [NUM_RANKS-1:0] rank_access,
    input wire logic [NUM_BANKS-1:0] page_close_req,
    input wire logic [NUM_RANKS-1:0] cke,
    input wire logic [NUM_RANKS-1:0] cmd_ok
);
    // ****
    // Shadow fields and idle runs
    // ****
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic [1:0] ckc_q, exc_q;
    logic [2:0] pgc_q;
    logic [4:0] pdc_q;
    logic [5:0] ridle_q, bidle_q;
    wire hit = reg_wr && reg_addr == IDLE_TIMING_ADDR;
    // Timing fields as written; only watched on rank 0 and bank 0 to stay small
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            {ckc_q, exc_q, pgc_q, pdc_q} <= {2'h0, 2'h3, 3'h7, 5'h1f};
        end else begin
            if (hit && reg_be[3]) ckc_q <= reg_wdata[31:30];
            if (hit && reg_be[1]) exc_q <= reg_wdata[9:8];
            if (hit && reg_be[0]) {pgc_q, pdc_q} <= reg_wdata[7:0];
        end
    end
    // Consecutive unaccessed clocks, saturating
    always_ff @(posedge clk_sys) begin
        if (!reset_n || rank_access[0]) ridle_q <= 6'h00;
        else if (ridle_q != 6'h3f) ridle_q <= ridle_q + 6'h01;
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n || bank_access[0] || !bank_open[0]) bidle_q <= 6'h00;
        else if (bidle_q != 6'h3f) bidle_q <= bidle_q + 6'h01;
    end
    a_cke_low_time: assert property ($fell(cke[0]) && ckc_q == CKE_LOW_DDR2 |-> !cke[0] [*3])
        else $error("cke low time short");
    a_exit_one_clk: assert property ($rose(cke[0]) && exc_q == EXIT_ONE |=> cmd_ok[0])
        else $error("one clock exit wrong");
    a_exit_two_clk: assert property ($rose(cke[0]) && exc_q == EXIT_TWO |=> !cmd_ok[0] ##1 cmd_ok[0])
        else $error("two clock exit wrong");
    a_no_cmd_wake: assert property ($rose(cke[0]) |-> !cmd_ok[0])
        else $error("command in wake clock");
    a_cmd_needs_cke: assert property (cmd_ok[0] |-> cke[0])
        else $error("command allowed while down");
    a_pd_idle_time: assert property ($fell(cke[0]) |-> pdc_q != PD_NEVER && ridle_q >= {1'b0, pdc_q})
        else $error("rank powered down early");
    a_pd_access_up: assert property (rank_access[0] && cke[0] |=> cke[0])
        else $error("busy rank powered down");
    a_page_idle_time: assert property ($rose(page_close_req[0]) |-> pgc_q == PAGE_EIGHT && bidle_q >= 6'h08)
        else $error("page close early");
    a_page_restart: assert property (bank_access[0] || !bank_open[0] |=> !page_close_req[0])
        else $error("page close after access");
endmodule : idle_pd_checker
bind dram_idle_power_down_timing idle_pd_checker i_idle_pd_checker (.clk_sys(clk_sys),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_be(reg_be),
    .reg_wdata(reg_wdata), .bank_access(bank_access), .bank_open(bank_open),
    .rank_access(rank_access), .page_close_req(page_close_req), .cke(cke), .cmd_ok(cmd_ok));
`default_nettype wire

// >>> dv/dram_rank_model.sv
// Behavioural DRAM rank that measures its clock-enable low time
`timescale 1ns/100ps
`default_nettype none
module dram_rank_model (
    // Clock and pins
    input wire logic clk_sys,
    input wire logic cke,
    input wire logic cmd,
    // Observations
    output logic [5:0] low_len,
    output logic bad_cmd
);
    // ****
    // Low-time and command watch
    // ****
    logic [5:0] run_q = 6'h00;
    initial low_len = 6'h00;
    initial bad_cmd = 1'b0;
    // A rank asleep cannot take a command, so one arriving is latched as an error
    always @(posedge clk_sys) begin
        run_q <= cke ? 6'h00 : run_q + 6'h01;
        if (cke && run_q != 6'h00) low_len <= run_q;
        if (cmd && !cke) bad_cmd <= 1'b1;
    end
endmodule : dram_rank_model
`default_nettype wire

// >>> dv/dram_idle_power_down_timing_bench.sv
// Self-checking bench for the idle timing and power-down block
`timescale 1ns/100ps
`default_nettype none
module dram_idle_power_down_timing_bench;
    import idle_pd_pkg::*;
    // ****
    // Stimulus and observation
    // ****
    logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid, bad_cmd;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [3:0] bank_access = 4'h0, bank_open = 4'h0, page_close_req, reg_be = 4'hf;
    logic [1:0] rank_access = 2'h3, cke, cmd_ok;
    logic [5:0] low_len;
    int miscompares = 0, samples_checked = 0;
    always #2 clk_sys = ~clk_sys;
    dram_idle_power_down_timing i_dram_idle_power_down_timing (.clk_sys(clk_sys),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .bank_access(bank_access), .bank_open(bank_open), .rank_access(rank_access),
        .page_close_req(page_close_req), .cke(cke), .cmd_ok(cmd_ok));
    dram_rank_model i_dram_rank_model (.clk_sys(clk_sys), .cke(cke[0]),
        .cmd(rank_access[0] & cmd_ok[0]), .low_len(low_len), .bad_cmd(bad_cmd));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_be <= be;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data is only trusted in the clock that carries the valid pulse
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        check(what, exp, (reg_rvalid === 1'b1) ? reg_rdata : ~exp);
    endtask : rd
    function automatic logic probe(input int s);
        return (s == 0) ? cke[0] : (s == 1) ? cmd_ok[0] : page_close_req[0];
    endfunction : probe
    task automatic wait_sig(input int s, input logic lvl, input int lim, output int n);
        n = 0;
        while (probe(s) !== lvl) begin
            @(negedge clk_sys);
            n++;
            if (n > lim) begin
                check("wait limit", 0, 1);
                complete_run();
            end
        end
    endtask : wait_sig
    // ****
    // Scenarios
    // ****
    task automatic t_regs;
        rd(12'h118, 32'h000003ff, "timing reset");
        rd(12'h120, 32'h40002801, "mode reset");
        wr(12'h118, 32'hffffffff, 4'hf);
        rd(12'h118, 32'hc00303ff, "timing writable bits");
        wr(12'h118, 32'h0000003f, 4'h1);
        rd(12'h118, 32'hc003033f, "timing low byte lane");
        wr(12'h120, 32'h20000000, 4'hf);
        rd(12'h120, 32'h60002801, "init flag");
        wr(12'h120, 32'h00000000, 4'h7);
        rd(12'h120, 32'h60002801, "init flag lane off");
        rd(12'h124, 32'h00000000, "unmapped read");
        $display("test regs done");
    endtask : t_regs
    task automatic t_pd(input logic [1:0] ck, input logic [1:0] ex, input logic [4:0] pd,
        input int lo, input int xd);
        int n;
        wr(12'h118, {ck, 20'h0, ex, 3'h7, pd}, 4'hf);
        @(posedge clk_sys);
        rank_access <= 2'h2;
        wait_sig(0, 1'b0, 60, n);
        check("idle clocks", 1, n >= pd && n <= pd + 3);
        check("busy rank cke", 1, cke[1]);
        @(posedge clk_sys);
        rank_access <= 2'h3;
        wait_sig(0, 1'b1, 20, n);
        wait_sig(1, 1'b1, 10, n);
        check("exit delay", xd, n);
        check("cke low time", 1, low_len >= lo);
        check("command asleep", 0, bad_cmd);
        $display("test power down done");
    endtask : t_pd
    task automatic t_pd_never;
        wr(12'h118, 32'h000003ff, 4'hf);
        @(posedge clk_sys);
        rank_access <= 2'h0;
        repeat (60) @(negedge clk_sys);
        check("cke timer off", 2'h3, cke);
        check("cmd ok timer off", 2'h3, cmd_ok);
        @(posedge clk_sys);
        rank_access <= 2'h3;
        $display("test timer off done");
    endtask : t_pd_never
    task automatic t_page(input logic [2:0] code);
        int n;
        wr(12'h118, {22'h0, 2'h3, code, 5'h1f}, 4'hf);
        @(posedge clk_sys);
        bank_open <= 4'h1;
        bank_access <= 4'h1;
        @(posedge clk_sys);
        bank_access <= 4'h0;
        if (code == PAGE_EIGHT) begin
            wait_sig(2, 1'b1, 20, n);
            check("page idle clocks", 1, n >= 8 && n <= 10);
            @(posedge clk_sys);
            bank_access <= 4'h1;
            @(posedge clk_sys);
            bank_access <= 4'h0;
            @(negedge clk_sys);
            check("page after access", 0, page_close_req[0]);
            // A long idle must not let the request lapse once the counter saturates
            repeat (80) @(negedge clk_sys);
            check("page request stands", 1, page_close_req[0]);
        end else begin
            repeat (30) @(negedge clk_sys);
            check("page never", 0, page_close_req);
        end
        @(posedge clk_sys);
        bank_open <= 4'h0;
        $display("test page done");
    endtask : t_page
    initial begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_regs();
        t_pd(2'h0, 2'h3, 5'h08, 1, 1);
        t_pd(2'h2, 2'h2, 5'h10, 3, 2);
        t_pd_never();
        t_page(3'h1);
        t_page(3'h7);
        complete_run();
    end
endmodule : dram_idle_power_down_timing_bench
`default_nettype wire
